// ===== hdl/blcd_core.sv
// Bit-map LCD driver core with Wishbone instruction port, display memory and drivers.
//
// Operation
// - Column level from frame and bit: high gives VDD/V2, low gives V5/V3.
// - Either edge on the reset/style pin starts reset initialization.
// - Pin level held after initialization selects 68 (high) or 80 (low) host style.
// - Primary strap makes frame pin an output; secondary makes it an input.
// - Secondary chip scans rows reversed, its outputs serve rows 31 down to 16.
// - Busy flag reads 1 during internal work; only status reads are then honoured.
// - Status read places the busy flag on data bit 7.
// - Five-bit start-line register names the line shown on row 0; it scrolls.
// - Start line is copied into the line counter whenever the frame signal changes.
// - Line counter advances with row scan and addresses the memory line read out.
// - Seven-bit presettable column counter increments after each data access, except reads in rmw mode.
// - Column counter saturates at 50H and goes no further.
// - Column increments never change the page; host sets the page explicitly.
// - Memory holds 2560 bits, one per pixel, one means dot on.
// - Host memory access is independent of readout and never disturbs the image.
// - Column direction setting reverses column address to output mapping.
// - Timing generator makes row timing and frame signal for 1/16 or 1/32 duty.
// - In 1/32 duty a primary and a secondary chip scan rows in step.
// - Each row period 80 bits of one memory line are latched for the drivers.
// - Display off and static drive act on latched data, never on memory.
// - Frame signal is a 50% clock tied to the frame and aligns a secondary.
// - Reset sets display off, line 0, static off, column 0, page 3, 1/32, adc 1, rmw off.
// - Row level from frame and scan data: V5, V1, VDD or V4.
// - Each rising line strobe latches display data and advances the line counter, unless the frame changes, which reloads it.
//
// Register access over Wishbone and the address map were chosen for this implementation.
`default_nettype none
`include "blcd_defines.svh"
module blcd_core (
   // Clock and reset.
   input  wire logic                        clk_i,
   input  wire logic                        rst_i,
   // Wishbone slave.
   input  wire logic                        cyc_i,
   input  wire logic                        stb_i,
   input  wire logic                        we_i,
   input  wire logic [3:0]                  adr_i,
   input  wire logic [3:0]                  sel_i,
   input  wire logic [31:0]                 dat_i,
   output logic      [31:0]                 dat_o,
   output logic                             ack_o,
   // Straps and timing pins from outside the clock domain.
   input  wire logic                        reset_style_i,
   input  wire logic                        primary_select_i,
   input  wire logic                        line_latch_strobe_i,
   input  wire logic                        master_clock_input_i,
   output logic                             master_clock_output_o,
   output logic                             host_style_80_o,
   // Two-way frame alternation pin.
   input  wire logic                        frame_alternation_signal_i,
   output logic                             frame_alternation_signal_o,
   output logic                             frame_alternation_signal_oe_n_o,
   // Drive level codes.
   output logic [`BLCD_ROWS-1:0][2:0]       row_drive_outputs_o,
   output logic [`BLCD_COLS-1:0][2:0]       column_drive_outputs_o
);
   blcd_pkg::blcd_state_e state_r;
   blcd_pkg::blcd_cfg_s   cfg_r;
   logic [3:0]            wait_r;
   logic [7:0]            ram_r [4][`BLCD_COLS];
   logic [`BLCD_COLS-1:0] latch_r;
   logic [`BLCD_COLS-1:0] eff_bits;
   logic [6:0]            col_r;
   logic [1:0]            page_r;
   logic [4:0]            start_r;
   logic [4:0]            line_r;
   logic [4:0]            row_pos_r;
   logic                  frame_r;
   logic                  style_r;
   logic                  rp_s1, rp_s2, rp_s3;
   logic                  pr_s1, pr_s2;
   logic                  ls_s1, ls_s2, ls_s3;
   logic                  fr_s1, fr_s2, fr_s3;
   logic                  mc_s1, mc_s2;
   logic                  req, wr_ok, cmd_wr, data_wr, data_rd, pin_edge, strobe;
   logic                  frame_chg, frame_now, soft_reset, busy;
   logic [4:0]            duty_last;
   logic [7:0]            wbyte, status;

   // Two-flop synchronisers; the third stage only feeds edge detection.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {rp_s1, rp_s2, rp_s3} <= 3'h0;
         {pr_s1, pr_s2}        <= 2'h0;
         {ls_s1, ls_s2, ls_s3} <= 3'h0;
         {fr_s1, fr_s2, fr_s3} <= 3'h0;
         {mc_s1, mc_s2}        <= 2'h0;
      end else begin
         {rp_s1, rp_s2, rp_s3} <= {reset_style_i, rp_s1, rp_s2};
         {pr_s1, pr_s2}        <= {primary_select_i, pr_s1};
         {ls_s1, ls_s2, ls_s3} <= {line_latch_strobe_i, ls_s1, ls_s2};
         {fr_s1, fr_s2, fr_s3} <= {frame_alternation_signal_i, fr_s1, fr_s2};
         {mc_s1, mc_s2}        <= {master_clock_input_i, mc_s1};
      end
   end

   // Bus request decode; writes arriving while busy are dropped, the bus still answers.
   assign req        = cyc_i & stb_i & ~ack_o;
   assign busy       = (state_r != blcd_pkg::ST_IDLE);
   assign wbyte      = dat_i[7:0];
   assign wr_ok      = req & we_i & sel_i[0] & ~busy;
   assign cmd_wr     = wr_ok & (adr_i == `BLCD_ADR_CMD);
   assign data_wr    = wr_ok & (adr_i == `BLCD_ADR_DATA);
   assign data_rd    = req & ~we_i & ~busy & (adr_i == `BLCD_ADR_DATA);
   assign soft_reset = cmd_wr & (wbyte == `BLCD_OP_RESET);
   assign pin_edge   = rp_s2 ^ rp_s3;
   assign strobe     = ls_s2 & ~ls_s3;
   assign duty_last  = cfg_r.duty32 ? `BLCD_DUTY32_LAST : `BLCD_DUTY16_LAST;
   assign frame_now  = pr_s2 ? frame_r : fr_s2;
   // A primary changes frame on its last row; a secondary follows the pin.
   assign frame_chg  = pr_s2 ? (strobe & (row_pos_r == duty_last))
                             : (fr_s2 ^ fr_s3);

   // Status byte: busy, column direction, display off, reset in progress.
   always_comb begin
      status                 = 8'h00;
      status[`BLCD_ST_BUSY]  = busy;
      status[`BLCD_ST_ADC]   = cfg_r.adc;
      status[`BLCD_ST_OFF]   = ~cfg_r.disp_on;
      status[`BLCD_ST_RESET] = (state_r == blcd_pkg::ST_INIT);
   end

   // Bus answer one cycle after the request; unmapped reads return zero.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= req;
         if (req & ~we_i) begin
            if (adr_i == `BLCD_ADR_STAT)
               dat_o <= {24'h00_0000, status};
            else if (data_rd & (col_r < `BLCD_COL_LIMIT))
               dat_o <= {24'h00_0000, ram_r[page_r][col_r]};
            else
               dat_o <= 32'h0000_0000;
         end
      end
   end

   // Sequencer: each accepted write or data read holds busy briefly; an init holds it longer.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= blcd_pkg::ST_INIT;
         wait_r  <= 4'(`BLCD_INIT_CYC - 1);
      end else if (pin_edge) begin
         state_r <= blcd_pkg::ST_INIT;
         wait_r  <= 4'(`BLCD_INIT_CYC - 1);
      end else begin
         unique case (state_r)
            blcd_pkg::ST_IDLE: begin
               if (wr_ok | data_rd) begin
                  state_r <= blcd_pkg::ST_BUSY;
                  wait_r  <= 4'(`BLCD_BUSY_CYC - 1);
               end
            end
            blcd_pkg::ST_BUSY, blcd_pkg::ST_INIT: begin
               if (wait_r == 4'h0)
                  state_r <= blcd_pkg::ST_IDLE;
               else
                  wait_r <= wait_r - 4'h1;
            end
            default: begin
               state_r <= blcd_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Host style is taken from the pin level once initialization ends.
   always_ff @(posedge clk_i) begin
      if (rst_i)
         style_r <= 1'b0;
      else if ((state_r == blcd_pkg::ST_INIT) & (wait_r == 4'h0) & ~pin_edge)
         style_r <= ~rp_s2;
   end
   assign host_style_80_o = style_r;

   // Configuration flags set by instructions and by initialization.
   always_ff @(posedge clk_i) begin
      if (rst_i | pin_edge) begin
         cfg_r <= '{disp_on: 1'b0, static_on: 1'b0, adc: 1'b1,
                    duty32: 1'b1, rmw: 1'b0};
      end else if (cmd_wr) begin
         if (wbyte[7:1] == `BLCD_OP_DISP)
            cfg_r.disp_on <= wbyte[0];
         if (wbyte[7:1] == `BLCD_OP_STATIC)
            cfg_r.static_on <= wbyte[0];
         if (wbyte[7:1] == `BLCD_OP_ADC)
            cfg_r.adc <= wbyte[0];
         if (wbyte[7:1] == `BLCD_OP_DUTY)
            cfg_r.duty32 <= wbyte[0];
         if (wbyte == `BLCD_OP_RMW)
            cfg_r.rmw <= 1'b1;
         if (wbyte == `BLCD_OP_END)
            cfg_r.rmw <= 1'b0;
      end
   end

   // Start line and page; the soft reset instruction restores only these two.
   always_ff @(posedge clk_i) begin
      if (rst_i | pin_edge | soft_reset) begin
         start_r <= `BLCD_RST_START;
         page_r  <= `BLCD_RST_PAGE;
      end else if (cmd_wr) begin
         if (wbyte[7:5] == `BLCD_OP_START)
            start_r <= wbyte[4:0];
         if (wbyte[7:2] == `BLCD_OP_PAGE)
            page_r <= wbyte[1:0];
      end
   end

   // Column counter: preset by instruction, counts per data access, locks at 50H.
   // Read-modify-write mode suppresses the step on reads only.
   always_ff @(posedge clk_i) begin
      if (rst_i | pin_edge) begin
         col_r <= `BLCD_RST_COL;
      end else if (cmd_wr & ~wbyte[7]) begin
         col_r <= wbyte[6:0];
      end else if ((data_wr | (data_rd & ~cfg_r.rmw)) & (col_r < `BLCD_COL_LIMIT)) begin
         col_r <= col_r + 7'h01;
      end
   end

   // Display memory; writes past the last column are dropped as no cell exists.
   always_ff @(posedge clk_i) begin
      if (data_wr & (col_r < `BLCD_COL_LIMIT))
         ram_r[page_r][col_r] <= wbyte;
   end

   // Row scan position and frame toggle; the primary owns the frame signal.
   always_ff @(posedge clk_i) begin
      if (rst_i | pin_edge) begin
         row_pos_r <= 5'h00;
         frame_r   <= 1'b0;
      end else if (frame_chg) begin
         row_pos_r <= 5'h00;
         if (pr_s2)
            frame_r <= ~frame_r;
      end else if (strobe) begin
         row_pos_r <= row_pos_r + 5'h01;
      end
   end
   assign frame_alternation_signal_o      = frame_r;
   assign frame_alternation_signal_oe_n_o = ~pr_s2;

   // Line counter: reload at each frame change, else step with every strobe.
   always_ff @(posedge clk_i) begin
      if (rst_i | pin_edge)
         line_r <= `BLCD_RST_START;
      else if (frame_chg)
         line_r <= start_r;
      else if (strobe)
         line_r <= line_r + 5'h01;
   end

   // Master clock passes through the primary only.
   always_ff @(posedge clk_i) begin
      if (rst_i)
         master_clock_output_o <= 1'b0;
      else
         master_clock_output_o <= mc_s2 & pr_s2;
   end

   // Per column: latch one memory line per strobe, then gate and drive.
   // Gating after the latch keeps memory untouched by display on/off and static drive.
   genvar c;
   generate
      for (c = 0; c < `BLCD_COLS; c = c + 1) begin : g_col
         always_ff @(posedge clk_i) begin
            if (rst_i)
               latch_r[c] <= 1'b0;
            else if (strobe)
               latch_r[c] <= ram_r[line_r[4:3]][c][line_r[2:0]];
         end
         assign eff_bits[c] = cfg_r.static_on | (cfg_r.disp_on & latch_r[c]);
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               column_drive_outputs_o[c] <= blcd_pkg::LV_V3;
            end else begin
               // Direction select picks the mirrored column when cleared.
               if (cfg_r.adc ? eff_bits[c] : eff_bits[`BLCD_COLS-1-c])
                  column_drive_outputs_o[c] <= frame_now ? blcd_pkg::LV_VDD
                                                         : blcd_pkg::LV_V5;
               else
                  column_drive_outputs_o[c] <= frame_now ? blcd_pkg::LV_V2
                                                         : blcd_pkg::LV_V3;
            end
         end
      end
   endgenerate

   // Per row: the selected row takes the select level, the rest stay unselected.
   genvar r;
   generate
      for (r = 0; r < `BLCD_ROWS; r = r + 1) begin : g_row
         logic sel_row;
         // A secondary output r serves row 31 - r.
         assign sel_row = pr_s2 ? (row_pos_r == 5'(r))
                                : (row_pos_r == 5'(`BLCD_LINES - 1 - r));
         always_ff @(posedge clk_i) begin
            if (rst_i)
               row_drive_outputs_o[r] <= blcd_pkg::LV_V4;
            else if (sel_row)
               row_drive_outputs_o[r] <= frame_now ? blcd_pkg::LV_V5
                                                   : blcd_pkg::LV_VDD;
            else
               row_drive_outputs_o[r] <= frame_now ? blcd_pkg::LV_V1
                                                   : blcd_pkg::LV_V4;
         end
      end
   endgenerate

   // Checks on the design's own behaviour.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_access;
      state_r == blcd_pkg::ST_IDLE && (wr_ok || data_rd);
   endsequence
   sequence s_busy_hold;
      busy [*2];
   endsequence

   a_busy_after_access: assert property (s_access |=> s_busy_hold)
      else $error("busy did not hold after an access");
   a_busy_on_bit7: assert property (ack_o && $past(req && !we_i && adr_i == `BLCD_ADR_STAT)
                                    |-> dat_o[7] == $past(busy))
      else $error("status bit 7 does not show busy");
   a_col_saturate: assert property (col_r == `BLCD_COL_LIMIT && data_wr
                                    |=> col_r == `BLCD_COL_LIMIT)
      else $error("column counter moved past its limit");
   a_col_step: assert property (data_wr && col_r < `BLCD_COL_LIMIT && !pin_edge
                                |=> col_r == $past(col_r) + 7'h01)
      else $error("column counter did not step after a write");
   a_page_kept: assert property (data_wr && !pin_edge |=> page_r == $past(page_r))
      else $error("page changed on a data write");
   a_line_reload: assert property (frame_chg && !pin_edge |=> line_r == $past(start_r))
      else $error("line counter not reloaded at frame change");
   a_line_step: assert property (strobe && !frame_chg && !pin_edge
                                 |=> line_r == 5'($past(line_r) + 5'h01))
      else $error("line counter did not advance on strobe");
   a_init_edge: assert property (pin_edge |=> state_r == blcd_pkg::ST_INIT
                                 && page_r == `BLCD_RST_PAGE && !cfg_r.disp_on)
      else $error("pin edge did not start initialization");
   a_frame_dir: assert property (frame_alternation_signal_oe_n_o == !pr_s2)
      else $error("frame pin direction wrong for strap");
   a_frame_toggle: assert property (pr_s2 && $past(pr_s2) && frame_chg && !pin_edge
                                    |=> frame_r != $past(frame_r))
      else $error("primary frame did not toggle");
   a_static_lights: assert property (cfg_r.static_on && frame_now
                                     |=> column_drive_outputs_o[0] == blcd_pkg::LV_VDD
                                         || $changed(frame_now))
      else $error("static drive did not light column");
endmodule
`default_nettype wire

// ===== hdl/blcd_defines.svh
// Register offsets, field positions, reset values, command codes and timing counts.
`ifndef BLCD_DEFINES_SVH
`define BLCD_DEFINES_SVH
`define BLCD_ADR_CMD      4'h0
`define BLCD_ADR_DATA     4'h4
`define BLCD_ADR_STAT     4'h8
`define BLCD_COLS         80
`define BLCD_ROWS         16
`define BLCD_LINES        32
`define BLCD_COL_LIMIT    7'h50
`define BLCD_COL_LAST     7'h4F
`define BLCD_DUTY16_LAST  5'h0F
`define BLCD_DUTY32_LAST  5'h1F
`define BLCD_RST_PAGE     2'h3
`define BLCD_RST_START    5'h00
`define BLCD_RST_COL      7'h00
`define BLCD_ST_BUSY      7
`define BLCD_ST_ADC       6
`define BLCD_ST_OFF       5
`define BLCD_ST_RESET     4
`define BLCD_OP_DISP      7'h57
`define BLCD_OP_ADC       7'h50
`define BLCD_OP_STATIC    7'h52
`define BLCD_OP_DUTY      7'h54
`define BLCD_OP_START     3'h6
`define BLCD_OP_PAGE      6'h2E
`define BLCD_OP_RMW       8'hE0
`define BLCD_OP_END       8'hEE
`define BLCD_OP_RESET     8'hE2
`define BLCD_CLK_MHZ      100
`define BLCD_BUSY_NS      40
`define BLCD_INIT_NS      100
`define BLCD_BUSY_CYC     ((`BLCD_BUSY_NS * `BLCD_CLK_MHZ + 999) / 1000)
`define BLCD_INIT_CYC     ((`BLCD_INIT_NS * `BLCD_CLK_MHZ + 999) / 1000)
`endif

// ===== hdl/blcd_pkg.sv
// Types shared by the bit-map LCD driver core.
`default_nettype none
package blcd_pkg;
   // Drive level codes for the row and column outputs.
   typedef enum logic [2:0] {
      LV_VDD = 3'h0,
      LV_V1  = 3'h1,
      LV_V2  = 3'h2,
      LV_V3  = 3'h3,
      LV_V4  = 3'h4,
      LV_V5  = 3'h5
   } blcd_level_e;
   // Control sequencer states.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_BUSY = 2'b01,
      ST_INIT = 2'b10
   } blcd_state_e;
   // Display configuration set by instructions.
   typedef struct packed {
      logic disp_on;
      logic static_on;
      logic adc;
      logic duty32;
      logic rmw;
   } blcd_cfg_s;
endpackage
`default_nettype wire

// ===== bench/blcd_strobe_src.sv
// Behavioural display-side timing source: line latch strobes and master clock bursts.
`default_nettype none
module blcd_strobe_src (
   // Burst control from the bench.
   input  wire logic       start_i,
   input  wire logic [5:0] count_i,
   output logic            done_o,
   // Timing pins toward the core.
   output logic            line_latch_strobe_o,
   output logic            master_clock_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pins stand still low between bursts; the odd timing keeps them unrelated to clk_i.
   initial begin
      done_o = 1'b0;
      line_latch_strobe_o = 1'b0;
      master_clock_o = 1'b0;
      forever begin
         wait (start_i === 1'b1);
         repeat (count_i) begin
            #33 line_latch_strobe_o = 1'b1;
            master_clock_o = 1'b1;
            #47 line_latch_strobe_o = 1'b0;
            master_clock_o = 1'b0;
         end
         done_o = 1'b1;
         wait (start_i === 1'b0);
         done_o = 1'b0;
      end
   end
endmodule
`default_nettype wire

// ===== bench/test_blcd_core.sv
// Self-checking bench for the bit-map LCD driver core over its Wishbone port.
`default_nettype none
module test_blcd_core;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i, rst_i, cyc_r, stb_r, we_r, pin_r, go_r, done, stb_pin, mclk, ack_o;
   logic [3:0] adr_r, sel_r;
   logic [31:0] dat_r, dat_o, q;
   logic [5:0] n_r;
   logic [15:0][2:0] rows;
   logic [79:0][2:0] cols;
   logic fr_o, fr_oe_n, style80;
   int err_count, n_tests;
   blcd_core u_blcd_core (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_r), .stb_i(stb_r),
      .we_i(we_r), .adr_i(adr_r), .sel_i(sel_r), .dat_i(dat_r), .dat_o(dat_o), .ack_o(ack_o),
      .reset_style_i(pin_r), .primary_select_i(1'b1), .line_latch_strobe_i(stb_pin),
      .master_clock_input_i(mclk), .master_clock_output_o(), .host_style_80_o(style80),
      .frame_alternation_signal_i(1'b0), .frame_alternation_signal_o(fr_o),
      .frame_alternation_signal_oe_n_o(fr_oe_n), .row_drive_outputs_o(rows),
      .column_drive_outputs_o(cols));
   blcd_strobe_src u_blcd_strobe_src (.start_i(go_r), .count_i(n_r), .done_o(done),
      .line_latch_strobe_o(stb_pin), .master_clock_o(mclk));
   // Free-running 100 MHz clock.
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task automatic end_of_test;
      if (err_count == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One classic cycle; ack and read data are taken at the rising edge that samples ack high.
   task automatic wb(input logic [3:0] a, input logic w, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      {cyc_r, stb_r, we_r, adr_r, sel_r, dat_r} <= {1'b1, 1'b1, w, a, 4'hF, 24'h0, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 100);
      if (n >= 100) err_count++;
      q = dat_o;
      {cyc_r, stb_r, we_r} <= 3'b000;
   endtask
   // Busy is polled before every instruction, since writes during busy are dropped.
   task automatic put(input logic [3:0] a, input logic [7:0] d, input logic w = 1'b1);
      int n;
      n = 0;
      do begin
         wb(4'h8, 1'b0, 8'h00);
         n++;
      end while (q[7] !== 1'b0 && n < 50);
      wb(a, w, d);
   endtask
   task automatic strobes(input logic [5:0] n);
      @(posedge clk_i);
      n_r <= n;
      go_r <= 1'b1;
      wait (done === 1'b1);
      @(posedge clk_i);
      go_r <= 1'b0;
      repeat (6) @(posedge clk_i);
   endtask
   // Hang guard: far above the several hundred cycles the sequence needs.
   initial begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      end_of_test();
   end
   initial begin
      {rst_i, cyc_r, stb_r, we_r, adr_r, sel_r, dat_r, pin_r, go_r, n_r} = '0;
      rst_i = 1'b1;
      err_count = 0;
      n_tests = 0;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      put(4'h8, 8'h00, 1'b0);
      chk(q[7:0], 8'h60);
      chk({5'h0, cols[0]}, {5'h0, blcd_pkg::LV_V3});
      wb(4'h0, 1'b1, 8'hB8);
      wb(4'h8, 1'b0, 8'h00);
      chk({7'h0, q[7]}, 8'h01);
      put(4'h0, 8'h00);
      put(4'h4, 8'h11);
      put(4'h0, 8'hB9);
      put(4'h0, 8'h00);
      put(4'h4, 8'h22);
      put(4'h0, 8'hB8);
      put(4'h0, 8'h00);
      put(4'h4, 8'h00, 1'b0);
      chk(q[7:0], 8'h11);
      put(4'h0, 8'hBA);
      put(4'h0, 8'h4E);
      put(4'h4, 8'hA5);
      put(4'h4, 8'h5A);
      put(4'h4, 8'h77);
      put(4'h0, 8'h4E);
      put(4'h4, 8'h00, 1'b0);
      chk(q[7:0], 8'hA5);
      put(4'h4, 8'h00, 1'b0);
      chk(q[7:0], 8'h5A);
      put(4'h4, 8'h00, 1'b0);
      chk(q[7:0], 8'h00);
      put(4'hC, 8'h00, 1'b0);
      chk(q[7:0], 8'h00);
      put(4'h0, 8'hA8);
      put(4'h0, 8'hA5);
      strobes(6'd16);
      chk({6'h0, fr_o, fr_oe_n}, 8'h02);
      chk({5'h0, cols[0]}, {5'h0, blcd_pkg::LV_VDD});
      chk({5'h0, rows[0]}, {5'h0, blcd_pkg::LV_V5});
      put(4'h0, 8'hA4);
      strobes(6'd1);
      chk({5'h0, cols[0]}, {5'h0, blcd_pkg::LV_V2});
      put(4'h0, 8'hA5);
      strobes(6'd15);
      chk({7'h0, fr_o}, 8'h00);
      chk({5'h0, cols[0]}, {5'h0, blcd_pkg::LV_V5});
      chk({5'h0, rows[0]}, {5'h0, blcd_pkg::LV_VDD});
      put(4'h0, 8'hAF);
      @(posedge clk_i);
      pin_r <= 1'b1;
      repeat (4) @(posedge clk_i);
      wb(4'h8, 1'b0, 8'h00);
      chk(q[7:0], 8'hF0);
      put(4'h4, 8'h3C);
      put(4'h0, 8'hBB);
      put(4'h0, 8'h00);
      put(4'h4, 8'h00, 1'b0);
      chk(q[7:0], 8'h3C);
      chk({7'h0, style80}, 8'h00);
      @(posedge clk_i);
      pin_r <= 1'b0;
      repeat (4) @(posedge clk_i);
      put(4'h8, 8'h00, 1'b0);
      chk({7'h0, style80}, 8'h01);
      end_of_test();
   end
endmodule
`default_nettype wire
